// ---- verilog/dtx_pkg.sv ----
// constants, carriers and mode table for the display transmitter host port
// Contract
// RQ1: pixels leave as one 16-bit 5-6-5 word per pixel.
// RQ2: transmitter pixel inputs above bit 15 are tied low outside this block.
// RQ3: vertical sync, horizontal sync, data enable and pixel clock go with pixels.
// RQ4: config port addresses 1110000 with a read/write bit after it.
// RQ5: config port runs at the 400 kHz or the 100 kHz rate, host's choice.
// RQ6: transmitter is set up over the config port before video or audio.
// RQ7: transmitter reads monitor capability data over its own display channel.
// RQ8: highest mode the capability data allows is chosen, 1280x1024 at most.
// RQ9: audio only in 640x480, 720x480, 1280x720 at 60 Hz and 1920x1080 at 24 Hz.
// RQ10: audio only when the running mode is a consumer-electronics timing.
// RQ11: transmitter raises its alert line on a display link state change.
// RQ12: stereo audio goes out on bit clock, serial data and word sync.
// RQ13: every audio clock is divided down from the 24.576 MHz reference.
// RQ14: a control stops the reference oscillator and frees its pin for general use.
// RQ15: transmitter may be put in standby or sleep when the link is idle.
// RQ16: pixel word, syncs and data enable change together on one pixel clock edge; stopping clears them at once, even with no pixel clock edge.
package dtx_pkg;
  localparam int unsigned DTX_CLK_HZ      = 50_000_000;
  localparam int unsigned DTX_FAST_HZ     = 400_000;
  localparam int unsigned DTX_STD_HZ      = 100_000;
  // quarter bus periods, rounded up so the bus never runs above its rate
  localparam logic [6:0]  DTX_FAST_QTR    =
    7'((DTX_CLK_HZ + 4 * DTX_FAST_HZ - 1) / (4 * DTX_FAST_HZ));
  localparam logic [6:0]  DTX_STD_QTR     =
    7'((DTX_CLK_HZ + 4 * DTX_STD_HZ - 1) / (4 * DTX_STD_HZ));
  localparam logic [6:0]  DTX_CFG_ADDR    = 7'h70;
  localparam int unsigned DTX_AUD_REF_HZ  = 24_576_000;
  localparam int unsigned DTX_AUD_BCLK_HZ = 3_072_000;
  localparam logic [1:0]  DTX_AUD_HALF    =
    2'(DTX_AUD_REF_HZ / (2 * DTX_AUD_BCLK_HZ) - 1);
  localparam int          DTX_MODES       = 14;
  localparam logic [3:0]  DTX_MODE_SAFE   = 4'hD;
  localparam logic [11:0] DTX_H_FRONT     = 12'h010;
  localparam logic [11:0] DTX_H_SYNC      = 12'h060;
  localparam logic [11:0] DTX_H_BACK      = 12'h030;
  localparam logic [11:0] DTX_V_FRONT     = 12'h00A;
  localparam logic [11:0] DTX_V_SYNC      = 12'h002;
  localparam logic [11:0] DTX_V_BACK      = 12'h021;
  // modes ranked by pixel rate, index 0 highest
  localparam logic [13:0] DTX_CEA_MASK    = 14'h2814;
  localparam logic [13:0][11:0] DTX_H_ACT = {
    12'h280, 12'h2D0, 12'h2D0, 12'h280, 12'h320, 12'h320, 12'h320,
    12'h320, 12'h400, 12'h780, 12'h400, 12'h500, 12'h400, 12'h500};
  localparam logic [13:0][11:0] DTX_V_ACT = {
    12'h1E0, 12'h190, 12'h1E0, 12'h1E0, 12'h258, 12'h258, 12'h258,
    12'h258, 12'h300, 12'h438, 12'h300, 12'h2D0, 12'h300, 12'h400};

  typedef struct packed {
    logic        vsync;
    logic        hsync;
    logic        de;
    logic [15:0] pixel;
  } dtx_video_t;

  typedef struct packed {
    logic [15:0] left;
    logic [15:0] right;
  } dtx_audio_t;

  typedef enum logic [4:0] {
    CFG_IDLE  = 5'h01,
    CFG_START = 5'h02,
    CFG_TX    = 5'h04,
    CFG_RX    = 5'h08,
    CFG_STOP  = 5'h10
  } dtx_cfg_state_t;
endpackage

// ---- verilog/dtx_host_port.sv ----
// host port driving a display transmitter: pixels, config bus, audio, alert
`timescale 1ns/100ps
`default_nettype none
module dtx_host_port
  import dtx_pkg::*;
(
  input  wire logic       mclk,                   // 50 MHz clock
  input  wire logic       rst_b,                  // async reset, active low
  input  wire logic [15:0] pix_in,                // 5-6-5 pixel word
  input  wire logic       pix_valid,              // pixel word offered
  output logic            pix_ready,              // buffer can take a word
  input  wire logic       vid_en,                 // run video timing
  input  wire logic [13:0] edid_mask,             // modes the monitor accepts
  output logic [3:0]      mode_idx,               // running mode
  output dtx_video_t      vid_out,                // syncs, enable, pixel
  output logic            pclk,                   // pixel clock
  input  wire logic       cfg_start,              // begin config transfer
  input  wire logic       cfg_read,               // 1 read, 0 write
  input  wire logic       cfg_fast,               // 1 fast rate, 0 standard
  input  wire logic [7:0] cfg_reg,                // transmitter register
  input  wire logic [7:0] cfg_wdata,              // write data
  output logic            cfg_busy,               // transfer running
  output logic            cfg_done,               // transfer finished pulse
  output logic            cfg_nack,               // transmitter did not ack
  output logic [7:0]      cfg_rdata,              // read data
  output logic            configured,             // one acked transfer seen
  input  wire logic       scl_i,                  // clock wire level
  output logic            scl_o,                  // clock drive value
  output logic            scl_oe,                 // pull clock low
  input  wire logic       sda_i,                  // data wire level
  output logic            sda_o,                  // data drive value
  output logic            sda_oe,                 // pull data low
  input  wire logic       aud_en,                 // allow audio
  input  wire dtx_audio_t aud_in,                 // stereo sample
  input  wire logic       aud_valid,              // sample offered
  output logic            aud_ready,              // sample latch free
  output logic            audio_active,           // audio running
  output logic            audio_bit_clock,        // serial bit clock
  output logic            audio_serial_data_pin,  // serial data
  output logic            audio_word_sync_pin,    // word sync
  input  wire logic       osc_off,                // stop reference oscillator
  output logic            osc_en,                 // oscillator enable
  input  wire logic       shared_oscillator_pin_i, // reference or general input
  output logic            shared_oscillator_pin_o, // general output value
  output logic            shared_oscillator_pin_oe, // general output enable
  input  wire logic       gpio_out,               // value for freed pin
  input  wire logic       gpio_oe,                // enable for freed pin
  output logic            gpio_in,                // freed pin level
  input  wire logic       alert_i,                // transmitter alert
  output logic            alert_event             // alert rise pulse
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // mode choice: lowest set bit is the highest rate the monitor takes
  logic [3:0] sel_mode;
  always_comb begin
    sel_mode = DTX_MODE_SAFE;
    for (int i = DTX_MODES - 1; i >= 0; i--) begin
      if (edid_mask[i]) begin
        sel_mode = 4'(i); // RQ8
      end
    end
  end

  // video timing
  logic        run;
  logic        upd;
  logic [11:0] hcnt;
  logic [11:0] vcnt;
  wire  [11:0] h_act   = DTX_H_ACT[mode_idx];
  wire  [11:0] v_act   = DTX_V_ACT[mode_idx];
  wire  [11:0] hs_beg  = h_act + DTX_H_FRONT;
  wire  [11:0] hs_end  = hs_beg + DTX_H_SYNC;
  wire  [11:0] h_last  = hs_end + DTX_H_BACK - 12'h001;
  wire  [11:0] vs_beg  = v_act + DTX_V_FRONT;
  wire  [11:0] vs_end  = vs_beg + DTX_V_SYNC;
  wire  [11:0] v_last  = vs_end + DTX_V_BACK - 12'h001;
  wire         de_now  = (hcnt < h_act) && (vcnt < v_act);
  wire         hs_now  = (hcnt >= hs_beg) && (hcnt < hs_end);
  wire         vs_now  = (vcnt >= vs_beg) && (vcnt < vs_end);
  assign run = vid_en && configured; // RQ6
  // pclk is high now, so this edge drops it: outputs settle half a period early
  assign upd = pclk;

  // two-entry pixel buffer
  logic [15:0] buf0;
  logic [15:0] buf1;
  logic [1:0]  cnt;
  wire         push   = pix_valid && pix_ready;
  wire         pop    = upd && de_now && (cnt != 2'h0);
  wire         wr_at0 = (cnt == 2'h0) || ((cnt == 2'h1) && pop);
  wire  [1:0]  next_cnt = cnt + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt       <= 2'h0;
      pix_ready <= 1'b0;
      buf0      <= 16'h0000;
      buf1      <= 16'h0000;
    end else begin
      cnt       <= next_cnt;
      pix_ready <= next_cnt != 2'h2;
      if (pop) begin
        buf0 <= buf1;
      end
      if (push && wr_at0) begin
        buf0 <= pix_in;
      end else if (push) begin
        buf1 <= pix_in;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pclk     <= 1'b0;
      hcnt     <= 12'h000;
      vcnt     <= 12'h000;
      mode_idx <= DTX_MODE_SAFE;
      vid_out  <= '0;
    end else if (!run) begin
      pclk     <= 1'b0;
      hcnt     <= 12'h000;
      vcnt     <= 12'h000;
      mode_idx <= sel_mode; // RQ8
      vid_out  <= '0;
    end else begin
      pclk <= ~pclk; // RQ3
      if (upd) begin
        // an empty buffer in the active area sends black rather than stalling
        vid_out <= '{vsync: vs_now, hsync: hs_now, de: de_now,
                     pixel: pop ? buf0 : 16'h0000}; // RQ1 RQ3 RQ16
        hcnt    <= (hcnt == h_last) ? 12'h000 : hcnt + 12'h001;
        if (hcnt == h_last) begin
          vcnt <= (vcnt == v_last) ? 12'h000 : vcnt + 12'h001;
        end
      end
    end
  end

  // stopping the timing clears the bus at once; only a running bus is held to the edge
  pix_edge_a: assert property ($changed(vid_out) && $past(run) |-> !pclk && $past(pclk))
    else $error("video word changed off the falling pixel clock edge"); // RQ16
  pix_blank_a: assert property (!vid_out.de |-> vid_out.pixel == 16'h0000)
    else $error("pixel word not zero outside active area"); // RQ1
  sync_de_a: assert property (vid_out.de |-> !vid_out.hsync && !vid_out.vsync)
    else $error("sync asserted inside active area"); // RQ3
  setup_first_a: assert property (pclk |-> configured)
    else $error("pixel clock running before transmitter setup"); // RQ6
  mode_pick_a: assert property ($rose(pclk) && $stable(edid_mask) && (edid_mask != 14'h0000)
                                |-> edid_mask[mode_idx])
    else $error("running mode not accepted by monitor"); // RQ8

  // config port master; no clock stretching, the transmitter never holds scl
  dtx_cfg_state_t state;
  logic [6:0]  qcnt;
  logic [1:0]  ph;
  logic [3:0]  bitn;
  logic [1:0]  byten;
  logic        c_read;
  logic        c_fast;
  logic [7:0]  c_reg;
  logic [7:0]  c_wdata;
  logic [7:0]  rx;
  wire         qtick  = (qcnt == 7'h00);
  wire  [6:0]  qload  = (c_fast ? DTX_FAST_QTR : DTX_STD_QTR) - 7'h01; // RQ5
  wire  [7:0]  tx_byte = (byten == 2'h0) ? {DTX_CFG_ADDR, 1'b0} :
                         (byten == 2'h1) ? c_reg :
                         c_read ? {DTX_CFG_ADDR, 1'b1} : c_wdata; // RQ4
  wire         tx_bit = tx_byte[~bitn[2:0]];
  wire         last_bit = (bitn == 4'h8);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= CFG_IDLE;
      qcnt <= 7'h00;
      ph <= 2'h0;
      bitn <= 4'h0;
      byten <= 2'h0;
      {c_read, c_fast, c_reg, c_wdata, rx} <= '0;
      {cfg_busy, cfg_done, cfg_nack, configured} <= 4'h0;
      cfg_rdata <= 8'h00;
      {scl_o, sda_o, scl_oe, sda_oe} <= 4'h0;
    end else begin
      cfg_done <= 1'b0;
      if (state == CFG_IDLE) begin
        if (cfg_start) begin
          state <= CFG_START; // RQ6
          {c_read, c_fast, c_reg, c_wdata} <= {cfg_read, cfg_fast, cfg_reg, cfg_wdata};
          qcnt <= 7'h00;
          ph <= 2'h0;
          byten <= 2'h0;
          cfg_busy <= 1'b1;
          cfg_nack <= 1'b0;
        end
      end else begin
        qcnt <= qtick ? qload : qcnt - 7'h01;
      end
      if (qtick && state != CFG_IDLE) begin
        ph <= ph + 2'h1;
        case (state)
          CFG_START: begin
            case (ph)
              2'h0: sda_oe <= 1'b0;
              2'h1: scl_oe <= 1'b0;
              2'h2: sda_oe <= 1'b1;
              default: begin
                scl_oe <= 1'b1;
                bitn <= 4'h0;
                state <= CFG_TX;
              end
            endcase
          end
          CFG_TX, CFG_RX: begin
            case (ph)
              2'h0: sda_oe <= (state == CFG_TX) && !last_bit && !tx_bit;
              2'h1: scl_oe <= 1'b0;
              2'h2: begin
                if (state == CFG_TX && last_bit && sda_i) begin
                  cfg_nack <= 1'b1; // RQ4
                end
                if (state == CFG_RX && !last_bit) begin
                  rx <= {rx[6:0], sda_i};
                end
              end
              default: begin
                scl_oe <= 1'b1;
                bitn <= last_bit ? 4'h0 : bitn + 4'h1;
                if (last_bit) begin
                  if (cfg_nack || state == CFG_RX || (byten == 2'h2 && !c_read)) begin
                    state <= CFG_STOP;
                  end else if (byten == 2'h2) begin
                    state <= CFG_RX;
                  end else begin
                    byten <= byten + 2'h1;
                    state <= (byten == 2'h1 && c_read) ? CFG_START : CFG_TX;
                  end
                end
              end
            endcase
          end
          CFG_STOP: begin
            case (ph)
              2'h0: sda_oe <= 1'b1;
              2'h1: scl_oe <= 1'b0;
              2'h2: sda_oe <= 1'b0;
              default: begin
                state <= CFG_IDLE;
                cfg_busy <= 1'b0;
                cfg_done <= 1'b1;
                cfg_rdata <= rx;
                configured <= configured | !cfg_nack; // RQ6
              end
            endcase
          end
          default: state <= CFG_IDLE;
        endcase
      end
    end
  end

  cfg_addr_a: assert property (state == CFG_TX && byten == 2'h0
                               |-> tx_byte == 8'hE0)
    else $error("config address byte is not 1110000 write"); // RQ4
  // the closing tick is left out: a new transfer may tick two cycles later
  cfg_rate_a: assert property (qtick && state != CFG_IDLE && !(state == CFG_STOP && ph == 2'h3)
                               |=> !qtick [*8])
    else $error("config bus quarter period too short"); // RQ5

  // audio: reference sampled as an asynchronous input through flops and edge-detected, divided to the bit clock
  logic        ref_s1;
  logic        ref_s2;
  logic        ref_s3;
  logic [1:0]  refcnt;
  logic [5:0]  bitcnt;
  logic [62:0] shreg;
  logic        aud_full;
  dtx_audio_t  aud_lat;
  wire         ref_rise = ref_s2 && !ref_s3;
  wire         aud_on   = osc_en && run && aud_en && DTX_CEA_MASK[mode_idx]; // RQ9 RQ10
  wire         bclk_tgl = aud_on && ref_rise && (refcnt == DTX_AUD_HALF);
  wire         bclk_fall = bclk_tgl && audio_bit_clock;
  wire         consume  = bclk_fall && (bitcnt == 6'h00);
  wire  [5:0]  next_bit = bitcnt + 6'h01;
  wire  [63:0] frame    = {aud_lat.left, 16'h0000, aud_lat.right, 16'h0000};
  wire         next_full = (aud_full && !consume) || (aud_valid && aud_ready);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      {ref_s1, ref_s2, ref_s3} <= 3'h0;
      aud_full <= 1'b0;
      aud_ready <= 1'b0;
      aud_lat <= '0;
    end else begin
      {ref_s1, ref_s2, ref_s3} <= {shared_oscillator_pin_i, ref_s1, ref_s2};
      aud_full <= next_full;
      aud_ready <= !next_full;
      if (aud_valid && aud_ready) begin
        aud_lat <= aud_in;
      end else if (consume) begin
        aud_lat <= '0; // a missed sample plays as silence
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      {audio_active, audio_bit_clock} <= 2'h0;
      {audio_serial_data_pin, audio_word_sync_pin} <= 2'h0;
      refcnt <= 2'h0;
      bitcnt <= 6'h00;
      shreg <= '0;
    end else if (!aud_on) begin
      {audio_active, audio_bit_clock} <= 2'h0;
      {audio_serial_data_pin, audio_word_sync_pin} <= 2'h0;
      refcnt <= 2'h0;
      bitcnt <= 6'h00;
    end else begin
      audio_active <= 1'b1;
      if (ref_rise) begin
        refcnt <= refcnt + 2'h1; // RQ13
      end
      if (bclk_tgl) begin
        audio_bit_clock <= !audio_bit_clock; // RQ12
      end
      if (bclk_fall) begin
        bitcnt <= next_bit;
        audio_word_sync_pin <= next_bit[5]; // RQ12
        if (bitcnt == 6'h00) begin
          {audio_serial_data_pin, shreg} <= frame;
        end else begin
          {audio_serial_data_pin, shreg} <= {shreg, 1'b0};
        end
      end
    end
  end

  aud_cea_a: assert property (audio_active |-> DTX_CEA_MASK[mode_idx])
    else $error("audio running in a mode without audio"); // RQ9 RQ10
  aud_sync_a: assert property ($changed(audio_word_sync_pin) && audio_active
                               |-> $fell(audio_bit_clock))
    else $error("word sync moved off the falling bit clock"); // RQ12
  aud_ref_a: assert property ($rose(audio_bit_clock) |-> $past(ref_rise))
    else $error("bit clock edge without reference edge"); // RQ13

  // oscillator control and the freed pin
  logic ref_alert;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      osc_en <= 1'b0;
      shared_oscillator_pin_o <= 1'b0;
      shared_oscillator_pin_oe <= 1'b0;
      gpio_in <= 1'b0;
      alert_event <= 1'b0;
    end else begin
      osc_en <= !osc_off; // RQ14
      shared_oscillator_pin_o <= gpio_out;
      shared_oscillator_pin_oe <= osc_off && gpio_oe; // RQ14
      gpio_in <= osc_off && shared_oscillator_pin_i;
      alert_event <= alert_i && !ref_alert;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ref_alert <= 1'b0;
    end else begin
      ref_alert <= alert_i;
    end
  end

  osc_free_a: assert property (shared_oscillator_pin_oe |-> !osc_en)
    else $error("freed pin driven while oscillator enabled"); // RQ14
endmodule // dtx_host_port
`default_nettype wire

// ---- tb/dtx_xmtr_model.sv ----
// behavioural transmitter: config port target, alert source, pixel input
`timescale 1ns/100ps
`default_nettype none
module dtx_xmtr_model
  import dtx_pkg::*;
(
  input  wire logic       scl,          // clock wire
  input  wire logic       sda,          // data wire
  input  wire logic       refuse,       // withhold every ack
  input  wire logic       link_change,  // display link changed state
  input  wire dtx_video_t vid,          // pixel bus from host
  output logic            sda_pull,     // pull data wire low
  output logic            alert,        // alert to host
  output logic [23:0]     got,          // last three bytes taken in
  output logic            low_pwr       // standby or sleep commanded
);
  // arbitrary answer byte; the host only has to hand it back unchanged
  localparam logic [7:0] READ_VAL = 8'hA5;
  // arbitrary power control register; nonzero data puts the link to sleep
  localparam logic [7:0] PWR_REG  = 8'h5A;
  logic [23:0] wide_pix;
  logic [7:0]  sh;
  logic        act;
  logic        rd;
  logic        ok;
  logic        tx;
  int          k;
  int          nb;
  assign wide_pix = {8'h00, vid.pixel};
  assign alert    = link_change;
  initial begin
    sda_pull = 1'b0;
    act = 1'b0;
    got = 24'h000000;
    low_pwr = 1'b0;
  end
  // start or repeated start: the first edge of scl after it closes no bit, it opens bit 0
  always @(negedge sda) if (scl === 1'b1) begin
    act = 1'b1;
    k = -1;
    nb = 0;
    rd = 1'b0;
    ok = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    act = 1'b0;
    sda_pull = 1'b0;
  end
  always @(posedge scl) if (act && k < 8) sh = {sh[6:0], sda};
  always @(negedge scl) if (act) begin
    k = k + 1;
    if (k == 9) begin
      k = 0;
      nb = nb + 1;
    end
    tx = rd && ok && nb > 0;
    if (k == 8 && !tx) begin
      if (nb == 0) begin
        ok = sh[7:1] == 7'h70 && !refuse;
        rd = sh[0];
      end
      got = {got[15:0], sh};
      if (nb == 2 && !rd && ok && got[15:8] == PWR_REG) begin
        low_pwr = sh != 8'h00;
      end
      sda_pull = ok;
    end else begin
      sda_pull = tx && k < 8 && !READ_VAL[7 - k];
    end
  end
endmodule // dtx_xmtr_model
`default_nettype wire

// ---- tb/dtx_host_port_tb_top.sv ----
// bench for the display transmitter host port
`timescale 1ns/100ps
`default_nettype none
module dtx_host_port_tb_top
  import dtx_pkg::*;
;
  logic        mclk, rst_b, pix_valid, vid_en, cfg_start, cfg_read, cfg_fast, aud_en;
  logic        aud_valid, osc_off, gpio_out, gpio_oe, refuse, link_change, ext_lvl, refclk;
  logic        pix_ready, pclk, cfg_busy, cfg_done, cfg_nack, configured, scl_o, scl_oe;
  logic        sda_o, sda_oe, aud_ready, audio_active, audio_bit_clock, osc_en, pin_o;
  logic        audio_serial_data_pin, audio_word_sync_pin, pin_oe, gpio_in;
  logic        alert_event, sda_pull, alert, pprev, low_pwr;
  logic [15:0] pix_in;
  logic [13:0] edid_mask;
  logic [7:0]  cfg_reg, cfg_wdata, cfg_rdata;
  logic [3:0]  mode_idx;
  logic [23:0] got;
  dtx_audio_t  aud_in;
  dtx_video_t  vid_out, vprev;
  wire logic   scl_w, sda_w, pin_w;
  int          n_mismatch, checked;
  assign scl_w = !(scl_oe && !scl_o);
  assign sda_w = !((sda_oe && !sda_o) || sda_pull);
  // the freed pin carries the host's own drive or an outside level
  assign pin_w = osc_off ? (pin_oe ? pin_o : ext_lvl) : refclk;
  dtx_host_port u_dtx_host_port (.mclk, .rst_b, .pix_in, .pix_valid, .pix_ready, .vid_en,
    .edid_mask, .mode_idx, .vid_out, .pclk, .cfg_start, .cfg_read, .cfg_fast, .cfg_reg,
    .cfg_wdata, .cfg_busy, .cfg_done, .cfg_nack, .cfg_rdata, .configured, .scl_i(scl_w),
    .scl_o, .scl_oe, .sda_i(sda_w), .sda_o, .sda_oe, .aud_en, .aud_in, .aud_valid,
    .aud_ready, .audio_active, .audio_bit_clock, .audio_serial_data_pin,
    .audio_word_sync_pin, .osc_off, .osc_en, .shared_oscillator_pin_i(pin_w),
    .shared_oscillator_pin_o(pin_o), .shared_oscillator_pin_oe(pin_oe), .gpio_out,
    .gpio_oe, .gpio_in, .alert_i(alert), .alert_event);
  dtx_xmtr_model u_dtx_xmtr_model (.scl(scl_w), .sda(sda_w), .refuse, .link_change,
    .vid(vid_out), .sda_pull, .alert, .got, .low_pwr);
  initial begin
    mclk = 1'b0;
    forever #10 mclk = !mclk;
  end
  initial begin
    refclk = 1'b0;
    forever #20.3 refclk = !refclk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("counts: %0d compared, %0d mismatched", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #1_600_000;
    n_mismatch++;
    stop_test;
  end
  // outputs may only move at the edge where the pixel clock falls
  always @(negedge mclk) begin
    if (rst_b && vid_en && vid_out !== vprev) check({pprev, pclk}, 2'b10);
    vprev = vid_out;
    pprev = pclk;
  end
  function automatic logic sel(input int w);
    case (w)
      0: return vid_out.de;
      1: return vid_out.hsync;
      2: return cfg_done;
      3: return audio_word_sync_pin;
      4: return audio_active;
      default: return alert_event;
    endcase
  endfunction
  task automatic tw(input int w, input logic lvl, input int lim, output int n);
    n = 0;
    while (sel(w) !== lvl && n < lim) begin
      @(negedge mclk);
      n++;
    end
    if (n >= lim) check(n, 0);
  endtask
  task automatic xfer(input logic rd, fast, input logic [7:0] r, d, input int len);
    int n;
    int q;
    q = fast ? DTX_FAST_QTR : DTX_STD_QTR;
    {cfg_read, cfg_fast, cfg_reg, cfg_wdata, cfg_start} = {rd, fast, r, d, 1'b1};
    @(negedge mclk);
    cfg_start = 1'b0;
    check(cfg_busy, 1);
    tw(2, 1'b1, 40000, n);
    check(n >= q * len - q && n <= q * len + 2, 1);
    @(negedge mclk);
  endtask
  task t_cfg;
    refuse = 1'b1;
    xfer(0, 1, 8'h11, 8'h22, 44);
    check({cfg_nack, configured}, 2'b10);
    refuse = 1'b0;
    xfer(0, 0, 8'h5A, 8'h3C, 116);
    check({cfg_nack, configured, low_pwr, got}, {3'b011, 24'hE05A3C});
    xfer(1, 1, 8'h6B, 8'h00, 156);
    check({cfg_nack, cfg_rdata, got}, {1'b0, 8'hA5, 24'hE06BE1});
    $display("test config done");
  endtask
  task automatic t_video;
    int n;
    pix_valid = 1'b1;
    pix_in = 16'hF81F;
    @(negedge mclk);
    pix_in = 16'h07E0;
    @(negedge mclk);
    check(pix_ready, 0);
    pix_valid = 1'b0;
    vid_en = 1'b1;
    tw(0, 1'b1, 200, n);
    check(vid_out, {3'b001, 16'hF81F});
    repeat (2) @(negedge mclk);
    check(vid_out, {3'b001, 16'h07E0});
    check(u_dtx_xmtr_model.wide_pix, 24'h0007E0);
    repeat (2) @(negedge mclk);
    check({pix_ready, vid_out}, {4'b1001, 16'h0000});
    tw(0, 1'b0, 2000, n);
    check(n, 2 * DTX_H_ACT[13] - 4);
    tw(1, 1'b1, 100, n);
    check(n, 32);
    tw(1, 1'b0, 300, n);
    check(n, 192);
    $display("test video done");
  endtask
  task automatic t_modes;
    int n;
    logic [13:0] m [3] = '{14'h3000, 14'h0A00, 14'h0000};
    logic [3:0]  e [3] = '{4'hC, 4'h9, 4'hD};
    logic [13:0] cea = 14'h2814;
    logic [3:0]  x;
    aud_in = {16'hC3A5, 16'h5A3C};
    {aud_en, aud_valid} = 2'b11;
    for (int i = 0; i < 17; i++) begin
      vid_en = 1'b0;
      edid_mask = i < 14 ? 14'(1) << i : m[i - 14];
      x = i < 14 ? 4'(i) : e[i - 14];
      repeat (3) @(negedge mclk);
      check(mode_idx, x);
      vid_en = 1'b1;
      if (cea[x]) tw(4, 1'b1, 3000, n);
      else repeat (1500) @(negedge mclk);
      check(audio_active, cea[x]);
    end
    $display("test modes done");
  endtask
  task automatic t_audio;
    int n;
    realtime t0;
    logic [15:0] l;
    logic [15:0] r;
    tw(3, 1'b1, 3000, n);
    tw(3, 1'b0, 3000, n);
    t0 = $realtime;
    tw(3, 1'b1, 3000, n);
    tw(3, 1'b0, 3000, n);
    check($realtime - t0 > 20700 && $realtime - t0 < 20970, 1);
    // the first rise after the word sync change carries the pad bit
    repeat (17) @(posedge audio_bit_clock) l = {l[14:0], audio_serial_data_pin};
    tw(3, 1'b1, 3000, n);
    repeat (17) @(posedge audio_bit_clock) r = {r[14:0], audio_serial_data_pin};
    check({l, r}, 32'hC3A55A3C);
    $display("test audio done");
  endtask
  task t_osc;
    {osc_off, gpio_oe, gpio_out} = 3'b111;
    repeat (3) @(negedge mclk);
    check({osc_en, pin_oe, pin_o, gpio_in}, 4'b0111);
    gpio_oe = 1'b0;
    ext_lvl = 1'b1;
    repeat (1500) @(negedge mclk);
    check({pin_oe, gpio_in, audio_active}, 3'b010);
    $display("test oscillator done");
  endtask
  task automatic t_alert;
    int n;
    link_change = 1'b1;
    tw(5, 1'b1, 4, n);
    check(n, 1);
    @(negedge mclk);
    check(alert_event, 0);
    link_change = 1'b0;
    $display("test alert done");
  endtask
  initial begin
    {pix_valid, vid_en, cfg_start, cfg_read, cfg_fast, aud_en, aud_valid, osc_off} = '0;
    {gpio_out, gpio_oe, refuse, link_change, ext_lvl, rst_b, pix_in, edid_mask} = '0;
    {cfg_reg, cfg_wdata, aud_in} = '0;
    repeat (4) @(negedge mclk);
    check({mode_idx, vid_out, pclk, cfg_busy}, {4'hD, 21'h0});
    rst_b = 1'b1;
    repeat (2) @(negedge mclk);
    check({pix_ready, aud_ready}, 2'b11);
    t_cfg;
    t_video;
    t_modes;
    t_audio;
    t_osc;
    t_alert;
    stop_test;
  end
endmodule // dtx_host_port_tb_top
`default_nettype wire
